// [cfgmap_pkg.sv]
// Shared constants and types of the serial configuration register bank
package cfgmap_pkg;

    // ==================================================
    // Register offsets
    localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
    localparam logic [7:0] ADDR_DEV_ID   = 8'h01;
    localparam logic [7:0] ADDR_CH_SEL   = 8'h05;
    localparam logic [7:0] ADDR_PWR      = 8'h08;
    localparam logic [7:0] ADDR_DIV      = 8'h0b;
    localparam logic [7:0] ADDR_SHUF     = 8'h0c;
    localparam logic [7:0] ADDR_COMMIT   = 8'hff;

    // ==================================================
    // Reset values, masks and field positions
    localparam logic [7:0] PORT_CFG_RST  = 8'h18;
    localparam logic [7:0] LSB_MASK      = 8'h42;
    localparam logic [7:0] SR_MASK       = 8'h24;
    localparam logic [7:0] CH_SEL_RST    = 8'hcf;
    localparam logic [7:0] CH_SEL_MASK   = 8'hcf;
    localparam logic [5:0] DIV_RST       = 6'h00;
    localparam int         DIV_W         = 6;
    localparam int         DIV_PHASE_LSB = 3;
    localparam int         PWR_PIN_BIT   = 5;
    localparam int         COMMIT_BIT    = 0;
    localparam int         PORT_CD_BIT   = 7;
    localparam int         PORT_AB_BIT   = 6;
    localparam int         NCH           = 4;
    // Arbitrary identification value
    localparam logic [7:0] DEV_ID        = 8'h5a;

    // ==================================================
    // Mode codes
    localparam logic [1:0] PM_NORMAL  = 2'h0;
    localparam logic [1:0] PM_FULL    = 2'h1;
    localparam logic [1:0] PM_STANDBY = 2'h2;
    localparam logic [1:0] SHUF_OFF   = 2'h0;
    localparam logic [1:0] SHUF_ON    = 2'h1;

    // ==================================================
    // Serial framing
    localparam logic [3:0] INSTR_LAST = 4'hf;
    localparam logic [2:0] BYTE_LAST  = 3'h7;
    localparam int         RW_BIT     = 15;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_INSTR = 2'b01,
        ST_DATA  = 2'b11
    } frame_st_t;

    typedef struct packed {
        logic sclk;
        logic csb_n;
        logic sdio;
    } spi_pins_t;

    typedef struct packed {
        logic [1:0] pwr;
        logic [1:0] shuf;
    } chan_cfg_t;

endpackage

// [chan_cfg_slot.sv]
// Shadow and active local settings of one converter channel
`timescale 1ns/1ps
module chan_cfg_slot (
    input  wire logic                  i_mclk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_wr_pwr,
    input  wire logic                  i_wr_shuf,
    input  wire logic [1:0]            i_wdata,
    input  wire logic                  i_commit,
    output cfgmap_pkg::chan_cfg_t      o_shadow,
    output cfgmap_pkg::chan_cfg_t      o_active
);
    cfgmap_pkg::chan_cfg_t sh_q, sh_d, act_q, act_d;

    always_comb begin
        sh_d  = sh_q;
        act_d = act_q;
        if (i_wr_pwr) begin
            sh_d.pwr = i_wdata;
        end
        if (i_wr_shuf) begin
            sh_d.shuf = i_wdata;
        end
        if (i_commit) begin
            act_d = sh_q;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            sh_q  <= '{pwr: cfgmap_pkg::PM_NORMAL, shuf: cfgmap_pkg::SHUF_ON};
            act_q <= '{pwr: cfgmap_pkg::PM_NORMAL, shuf: cfgmap_pkg::SHUF_ON};
        end else begin
            sh_q  <= sh_d;
            act_q <= act_d;
        end
    end

    assign o_shadow = sh_q;
    assign o_active = act_q;

    AST_CH_COMMIT: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_commit |=> o_active == $past(o_shadow))
        else $error("channel commit did not copy shadow");

    AST_CH_HOLD: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_wr_shuf && !i_commit) |=> $stable(o_active))
        else $error("channel active changed without commit");

endmodule // chan_cfg_slot

// [cfg_regbank.sv]
// Serial-port configuration register bank of the quad receiver
`timescale 1ns/1ps
// Function
// - Only listed addresses and bits exist; others read zero, writes ignored.
// - Port config: bit order bits 6/1, soft reset 5/2, resets 0x18.
// - Channel bits 3..0 steer local writes; register resets to 0xCF.
// - Channel bit 7 enables port C/D, bit 6 port A/B.
// - Transfer bit 0 copies every shadow into active at once.
// - Power bit 5: pin gives full power-down when 0, standby when 1.
// - Local power code 00 normal, 01 full power-down, 10 standby.
// - Divider ratio bits 2..0 divide clock by value plus one.
// - Divider phase bits 5..3 delay divided clock by that many cycles.
// - Local shuffle code 00 off, 01 on; resets to on.
// - Addresses 0x08..0x3E are shadowed; transfer bit self-clears.
// - Read with several channels selected returns channel A.
// - Channel selection affects no global register except port config, which is written only with channel bits 3..0 all set.
// - Frame: 16-bit instruction, read/write first (last when LSB first), then 8-bit words.
module cfg_regbank (
    input  wire logic                       I_MCLK,
    input  wire logic                       I_NRST,
    input  wire cfgmap_pkg::spi_pins_t      I_SPI,
    input  wire logic                       I_PDWN,
    output logic                            O_SDIO,
    output logic                            O_SDIO_OE_N,
    output cfgmap_pkg::chan_cfg_t [3:0]     O_CH_CFG,
    output logic [1:0]                      O_PORT_EN,
    output logic                            O_SAMPLE_EN
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);

    cfgmap_pkg::spi_pins_t  pins_q;
    cfgmap_pkg::frame_st_t  st_q, st_d;
    logic                   sclk_prev_q, rise;
    logic [3:0]             bcnt_q, bcnt_d;
    logic [15:0]            sh_q, sh_d, sh_in;
    logic                   rd_q, rd_d;
    logic [7:0]             addr_q, addr_d;
    logic                   sdo_q, sdo_d, oe_n_q, oe_n_d;
    logic                   wr_stb;
    logic [7:0]             wr_data, rd_byte;
    logic                   lsb_q, lsb_d, soft_q, soft_d, commit_q, commit_d;
    logic [7:0]             chsel_q, chsel_d;
    logic                   pin_sb_sh_q, pin_sb_sh_d, pin_sb_act_q, pin_sb_act_d;
    logic [5:0]             div_sh_q, div_sh_d, div_act_q, div_act_d;
    logic                   regs_nrst;
    logic [1:0]             rd_ch;
    cfgmap_pkg::chan_cfg_t  ch_sh [4];
    cfgmap_pkg::chan_cfg_t  ch_act [4];
    logic [2:0]             ratio, phase, dcnt_q, dcnt_d;
    logic [6:0]             dly_q, dly_d;
    logic                   raw, smp_d;
    cfgmap_pkg::chan_cfg_t [3:0] ch_out_d;

    // ==================================================
    // Serial frame engine
    assign rise    = pins_q.sclk & ~sclk_prev_q;
    assign sh_in   = lsb_q ? {pins_q.sdio, sh_q[15:1]} : {sh_q[14:0], pins_q.sdio};
    assign wr_data = lsb_q ? sh_in[15:8] : sh_in[7:0];

    always_comb begin
        st_d   = st_q;
        bcnt_d = bcnt_q;
        sh_d   = sh_q;
        rd_d   = rd_q;
        addr_d = addr_q;
        wr_stb = 1'b0;
        oe_n_d = 1'b1;
        // Read bit for the current position; ~x is 7-x on three bits
        sdo_d  = rd_byte[lsb_q ? bcnt_q[2:0] : ~bcnt_q[2:0]];
        if (pins_q.csb_n) begin
            st_d = cfgmap_pkg::ST_IDLE;
        end else begin
            case (st_q)
                cfgmap_pkg::ST_IDLE: begin
                    st_d   = cfgmap_pkg::ST_INSTR;
                    bcnt_d = '0;
                end
                cfgmap_pkg::ST_INSTR: begin
                    if (rise) begin
                        sh_d   = sh_in;
                        bcnt_d = 4'(bcnt_q + 4'h1);
                        if (bcnt_q == cfgmap_pkg::INSTR_LAST) begin
                            st_d   = cfgmap_pkg::ST_DATA;
                            rd_d   = sh_in[cfgmap_pkg::RW_BIT];
                            addr_d = sh_in[7:0];
                            bcnt_d = '0;
                        end
                    end
                end
                cfgmap_pkg::ST_DATA: begin
                    oe_n_d = ~rd_q;
                    if (rise) begin
                        sh_d   = sh_in;
                        bcnt_d = 4'(bcnt_q + 4'h1);
                        if (bcnt_q[2:0] == cfgmap_pkg::BYTE_LAST) begin
                            wr_stb = ~rd_q;
                            addr_d = 8'(addr_q + 8'h01);
                            bcnt_d = '0;
                        end
                    end
                end
                default: st_d = cfgmap_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            pins_q      <= '{sclk: 1'b0, csb_n: 1'b1, sdio: 1'b0};
            sclk_prev_q <= 1'b0;
            st_q        <= cfgmap_pkg::ST_IDLE;
            bcnt_q      <= '0;
            sh_q        <= '0;
            rd_q        <= 1'b0;
            addr_q      <= '0;
            sdo_q       <= 1'b0;
            oe_n_q      <= 1'b1;
        end else begin
            pins_q      <= I_SPI;
            sclk_prev_q <= pins_q.sclk;
            st_q        <= st_d;
            bcnt_q      <= bcnt_d;
            sh_q        <= sh_d;
            rd_q        <= rd_d;
            addr_q      <= addr_d;
            sdo_q       <= sdo_d;
            oe_n_q      <= oe_n_d;
        end
    end

    assign O_SDIO      = sdo_q;
    assign O_SDIO_OE_N = oe_n_q;

    // ==================================================
    // Global registers
    always_comb begin
        lsb_d        = lsb_q;
        chsel_d      = chsel_q;
        pin_sb_sh_d  = pin_sb_sh_q;
        pin_sb_act_d = pin_sb_act_q;
        div_sh_d     = div_sh_q;
        div_act_d    = div_act_q;
        soft_d       = 1'b0;
        commit_d     = 1'b0;
        if (wr_stb) begin
            case (addr_q)
                cfgmap_pkg::ADDR_PORT_CFG: begin
                    if (&chsel_q[cfgmap_pkg::NCH-1:0]) begin
                        if (|(wr_data & cfgmap_pkg::SR_MASK)) begin
                            soft_d = 1'b1;
                        end else begin
                            lsb_d = |(wr_data & cfgmap_pkg::LSB_MASK);
                        end
                    end
                end
                cfgmap_pkg::ADDR_CH_SEL: chsel_d = wr_data & cfgmap_pkg::CH_SEL_MASK;
                cfgmap_pkg::ADDR_PWR:    pin_sb_sh_d = wr_data[cfgmap_pkg::PWR_PIN_BIT];
                cfgmap_pkg::ADDR_DIV:    div_sh_d = wr_data[cfgmap_pkg::DIV_W-1:0];
                cfgmap_pkg::ADDR_COMMIT: commit_d = wr_data[cfgmap_pkg::COMMIT_BIT];
                default: ;
            endcase
        end
        // shadow to active, strobe is one cycle
        if (commit_q) begin
            pin_sb_act_d = pin_sb_sh_q;
            div_act_d    = div_sh_q;
        end
    end

    // Soft reset is held apart so it can clear itself
    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= soft_d;
        end
    end

    assign regs_nrst = I_NRST & ~soft_q;

    always_ff @(posedge I_MCLK) begin
        if (!regs_nrst) begin
            lsb_q        <= 1'b0;
            chsel_q      <= cfgmap_pkg::CH_SEL_RST;
            pin_sb_sh_q  <= 1'b0;
            pin_sb_act_q <= 1'b0;
            div_sh_q     <= cfgmap_pkg::DIV_RST;
            div_act_q    <= cfgmap_pkg::DIV_RST;
            commit_q     <= 1'b0;
        end else begin
            lsb_q        <= lsb_d;
            chsel_q      <= chsel_d;
            pin_sb_sh_q  <= pin_sb_sh_d;
            pin_sb_act_q <= pin_sb_act_d;
            div_sh_q     <= div_sh_d;
            div_act_q    <= div_act_d;
            commit_q     <= commit_d;
        end
    end

    // ==================================================
    // Local registers, one slot per channel
    for (genvar c = 0; c < cfgmap_pkg::NCH; c++) begin : g_ch
        chan_cfg_slot u_slot (
            .i_mclk    (I_MCLK),
            .i_nrst    (regs_nrst),
            .i_wr_pwr  (wr_stb && addr_q == cfgmap_pkg::ADDR_PWR && chsel_q[c]),
            .i_wr_shuf (wr_stb && addr_q == cfgmap_pkg::ADDR_SHUF && chsel_q[c]),
            .i_wdata   (wr_data[1:0]),
            .i_commit  (commit_q),
            .o_shadow  (ch_sh[c]),
            .o_active  (ch_act[c])
        );
    end

    // ==================================================
    // Read path
    always_comb begin
        // only a lone selection moves away from channel A
        rd_ch = '0;
        for (int c = 1; c < cfgmap_pkg::NCH; c++) begin
            if (chsel_q[cfgmap_pkg::NCH-1:0] == 4'(4'h1 << c)) begin
                rd_ch = 2'(c);
            end
        end
        case (addr_q)
            cfgmap_pkg::ADDR_PORT_CFG: rd_byte = cfgmap_pkg::PORT_CFG_RST | (lsb_q ? cfgmap_pkg::LSB_MASK : 8'h00);
            cfgmap_pkg::ADDR_DEV_ID:   rd_byte = cfgmap_pkg::DEV_ID;
            cfgmap_pkg::ADDR_CH_SEL:   rd_byte = chsel_q;
            cfgmap_pkg::ADDR_PWR:      rd_byte = (8'(pin_sb_sh_q) << cfgmap_pkg::PWR_PIN_BIT) | 8'(ch_sh[rd_ch].pwr);
            cfgmap_pkg::ADDR_DIV:      rd_byte = 8'(div_sh_q);
            cfgmap_pkg::ADDR_SHUF:     rd_byte = 8'(ch_sh[rd_ch].shuf);
            default:                   rd_byte = 8'h00;
        endcase
    end

    // ==================================================
    // Sample clock divider and channel outputs
    localparam int DIV_PHASE_LSB_M1 = cfgmap_pkg::DIV_PHASE_LSB - 1;
    assign ratio = div_act_q[DIV_PHASE_LSB_M1:0];
    assign phase = div_act_q[cfgmap_pkg::DIV_PHASE_LSB +: 3];
    assign raw   = (dcnt_q == 3'h0);

    always_comb begin
        // count 0..ratio; restart on commit to realign
        if (commit_q || dcnt_q == ratio) begin
            dcnt_d = 3'h0;
        end else begin
            dcnt_d = dcnt_q + 3'h1;
        end
        dly_d = {dly_q[5:0], raw};
        smp_d = (phase == 3'h0) ? raw : dly_q[3'(phase - 3'h1)];
        for (int c = 0; c < cfgmap_pkg::NCH; c++) begin
            ch_out_d[c] = ch_act[c];
            if (I_PDWN) begin
                ch_out_d[c].pwr = pin_sb_act_q ? cfgmap_pkg::PM_STANDBY : cfgmap_pkg::PM_FULL;
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            dcnt_q      <= 3'h0;
            dly_q       <= '0;
            O_SAMPLE_EN <= 1'b0;
            O_CH_CFG    <= '0;
            O_PORT_EN   <= '0;
        end else begin
            dcnt_q      <= dcnt_d;
            dly_q       <= dly_d;
            O_SAMPLE_EN <= smp_d;
            O_CH_CFG    <= ch_out_d;
            O_PORT_EN   <= {chsel_q[cfgmap_pkg::PORT_CD_BIT], chsel_q[cfgmap_pkg::PORT_AB_BIT]};
        end
    end

    // ==================================================
    // Checks
    sequence no_commit3;
        !commit_q [*3];
    endsequence

    sequence wr_div_to(logic [7:0] sel);
        wr_stb && addr_q == cfgmap_pkg::ADDR_DIV && chsel_q == sel;
    endsequence

    AST_SOFT_RESET: assert property (soft_q |=> !soft_q && chsel_q == cfgmap_pkg::CH_SEL_RST && !lsb_q)
        else $error("soft reset did not restore defaults");
    AST_BIT_ORDER: assert property ((wr_stb && addr_q == 8'h00 && &chsel_q[3:0] && wr_data == 8'h42)
        |=> lsb_q)
        else $error("bit order select not taken");
    AST_LOCAL_STEER: assert property ((wr_stb && addr_q == 8'h08 && chsel_q[3:0] == 4'h4)
        |=> $stable(ch_sh[0]) && $stable(ch_sh[1]))
        else $error("local write reached unselected channel");
    AST_COMMIT: assert property (commit_q |=> div_act_q == $past(div_sh_q) && !commit_q)
        else $error("transfer did not commit or clear");
    AST_SHADOW: assert property ((wr_stb && addr_q == 8'h0b && !commit_q) |=> $stable(div_act_q))
        else $error("shadowed write took effect early");
    AST_GLOBAL: assert property (wr_div_to(8'h84) |=> div_sh_q == $past(wr_data[5:0]))
        else $error("global write gated by channel selection");
    AST_PIN_MODE: assert property ((I_PDWN && pin_sb_act_q && !commit_q)
        |=> O_CH_CFG[0].pwr == 2'h2 && O_CH_CFG[3].pwr == 2'h2)
        else $error("power-down pin mode wrong");
    AST_RATIO: assert property ((raw && ratio == 3'h3 && !commit_q) ##1 no_commit3 ##1 1'b1 |-> raw)
        else $error("divide by four period wrong");
    AST_PHASE: assert property ((raw && phase == 3'h2 && !commit_q) ##1 no_commit3 |-> O_SAMPLE_EN)
        else $error("divider phase delay wrong");
    AST_READ_A: assert property ((st_q == cfgmap_pkg::ST_DATA && addr_q == 8'h0c && chsel_q[3:0] == 4'hf)
        |-> rd_byte == 8'(ch_sh[0].shuf))
        else $error("multi-channel read not channel A");

endmodule // cfg_regbank

// [spi_host_model.sv]
// Serial port host model for the configuration link
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic             i_mclk,
    input  wire logic             i_sdio,
    input  wire logic             i_sdio_oe_n,
    output cfgmap_pkg::spi_pins_t o_spi
);
    logic drv_q   = 1'b1;
    logic bit_q   = 1'b0;
    logic sclk_q  = 1'b0;
    logic csb_n_q = 1'b1;

    // ==================================================
    // Pin levels
    assign o_spi.sclk  = sclk_q;
    assign o_spi.csb_n = csb_n_q;
    // No pull on the data line, so a released line flips
    assign o_spi.sdio  = (i_sdio_oe_n === 1'b0) ? i_sdio : (drv_q ? bit_q : !bit_q);

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    // ==================================================
    // Frame with one data byte
    // instruction then byte
    task automatic xfer(input logic rd, input logic [7:0] addr, input logic [7:0] wd,
                        input logic lsb, output logic [7:0] rdata);
        logic [23:0] frame;
        int          k;
        frame   = {rd, 7'h00, addr, wd};
        rdata   = 8'h00;
        csb_n_q = 1'b0;
        for (int i = 0; i < 24; i++) begin
            k = !lsb ? 23 - i : (i < 16 ? 8 + i : i - 16);
            // Let go at the first data bit, after the design has turned the line round
            if (rd && i == 16)
                drv_q = 1'b0;
            if (drv_q)
                bit_q = frame[k];
            tick(4);
            if (!drv_q)
                rdata[k] = o_spi.sdio;
            sclk_q = 1'b1;
            tick(4);
            sclk_q = 1'b0;
        end
        tick(1);
        csb_n_q = 1'b1;
        drv_q   = 1'b1;
        tick(4);
    endtask
endmodule // spi_host_model

// [test_cfg_regbank.sv]
// Self-checking testbench of the configuration register bank
`timescale 1ns/1ps
module test_cfg_regbank;
    logic                        mclk;
    logic                        nrst;
    logic                        pdwn;
    logic                        lsb;
    cfgmap_pkg::spi_pins_t       spi;
    logic                        sdio;
    logic                        sdio_oe_n;
    cfgmap_pkg::chan_cfg_t [3:0] ch_cfg;
    logic [1:0]                  port_en;
    logic                        sample_en;
    int                          bad_count = 0;
    int                          check_count = 0;
    int                          d0;
    int                          dn;
    int                          per;
    logic [7:0]                  ra [8] = '{8'h00, 8'h01, 8'h05, 8'h08, 8'h0b, 8'h0c, 8'hff, 8'h02};
    logic [7:0]                  rv [8] = '{8'h18, cfgmap_pkg::DEV_ID, 8'hcf, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    logic [7:0]                  dv [4] = '{8'h00, 8'h03, 8'h07, 8'h17};

    cfg_regbank dut_u (
        .I_MCLK      (mclk),
        .I_NRST      (nrst),
        .I_SPI       (spi),
        .I_PDWN      (pdwn),
        .O_SDIO      (sdio),
        .O_SDIO_OE_N (sdio_oe_n),
        .O_CH_CFG    (ch_cfg),
        .O_PORT_EN   (port_en),
        .O_SAMPLE_EN (sample_en)
    );

    spi_host_model host_u (
        .i_mclk      (mclk),
        .i_sdio      (sdio),
        .i_sdio_oe_n (sdio_oe_n),
        .o_spi       (spi)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ==================================================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        host_u.xfer(1'b0, a, d, lsb, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        host_u.xfer(1'b1, a, 8'h00, lsb, r);
        check({8'h00, r}, {8'h00, e});
    endtask

    // Cycles to the next enable pulse, then the pulse spacing
    task automatic measure(output int d, output int p);
        d = 0;
        while (sample_en !== 1'b1 && d < 16) begin
            tick(1);
            d++;
        end
        p = 0;
        do begin
            tick(1);
            p++;
        end while (sample_en !== 1'b1 && p < 16);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==================================================
    // Scenarios
    initial begin
        nrst = 1'b0;
        pdwn = 1'b0;
        lsb  = 1'b0;
        tick(2);
        nrst = 1'b1;
        tick(2);
        check(ch_cfg, 16'h1111);
        check(16'(port_en), 16'h0003);
        for (int i = 0; i < 8; i++)
            rd_chk(ra[i], rv[i]);
        // Shuffle off stays in shadow until committed
        wr(8'h0c, 8'h00);
        check(ch_cfg, 16'h1111);
        rd_chk(8'h0c, 8'h00);
        wr(8'hff, 8'h01);
        check(ch_cfg, 16'h0000);
        rd_chk(8'hff, 8'h00);
        for (logic [2:0] c = 3'h0; c < 3'h3; c++) begin
            wr(8'h08, {6'h00, c[1:0]});
            wr(8'hff, 8'h01);
            check(ch_cfg, {4{c[1:0], 2'b00}});
        end
        wr(8'h05, 8'h84);
        check(16'(port_en), 16'h0002);
        wr(8'h08, 8'h01);
        wr(8'hff, 8'h01);
        check(ch_cfg, 16'h8488);
        rd_chk(8'h08, 8'h01);
        wr(8'h08, 8'h20);
        wr(8'hff, 8'h01);
        pdwn = 1'b1;
        tick(4);
        check(ch_cfg, 16'h8888);
        wr(8'h08, 8'h00);
        wr(8'hff, 8'h01);
        check(ch_cfg, 16'h4444);
        pdwn = 1'b0;
        tick(4);
        check(ch_cfg, 16'h8088);
        for (int i = 0; i < 4; i++) begin
            wr(8'h0b, dv[i]);
            wr(8'hff, 8'h01);
            measure(dn, per);
            check(16'(per), {13'h0000, dv[i][2:0]} + 16'h0001);
            if (i == 2)
                d0 = dn;
        end
        check(16'((dn - d0 + 8) % 8), 16'h0002);
        wr(8'h05, 8'h4f);
        check(16'(port_en), 16'h0001);
        rd_chk(8'h08, 8'h02);
        // Port config refused unless every channel is selected
        wr(8'h05, 8'hc4);
        wr(8'h00, 8'h42);
        rd_chk(8'h00, 8'h18);
        wr(8'h05, 8'hcf);
        wr(8'h00, 8'h42);
        lsb = 1'b1;
        rd_chk(8'h00, 8'h5a);
        rd_chk(8'h05, 8'hcf);
        wr(8'h00, 8'h18);
        lsb = 1'b0;
        rd_chk(8'h00, 8'h18);
        wr(8'h05, 8'h8f);
        wr(8'h00, 8'h24);
        rd_chk(8'h05, 8'hcf);
        rd_chk(8'h0c, 8'h01);
        rd_chk(8'h0b, 8'h00);
        check(ch_cfg, 16'h1111);
        check(16'(port_en), 16'h0003);
        rd_chk(8'h00, 8'h18);
        check(16'(sdio_oe_n), 16'h0001);
        complete_run();
    end

    // Runs near 50 us; four times that means a hang
    initial begin
        #200000;
        bad_count++;
        complete_run();
    end
endmodule // test_cfg_regbank
